// [wwd_pkg.sv]
// Package for the windowed watchdog: configuration word layout, encodings, register map.
// Assumes a single 40 MHz system clock; oscillator ticks arrive as pins and are synchronised.
package wwd_pkg;

	// Configuration word (24 bits) field positions
	localparam int CFG_W = 24;
	localparam int POS_PS = 0;
	localparam int POS_PSA = 4;
	localparam int POS_EN = 5;
	localparam int POS_WIN_DIS = 7;
	localparam int POS_WIN = 8;
	localparam int POS_UNUSED10 = 10;
	localparam int POS_CMX = 11;
	localparam int POS_CLK = 13;

	// Unimplemented bits (23:15, 12, 10) read as one
	localparam logic [23:0] CFG_ONES_MASK = 24'hff9400;
	localparam logic [23:0] CFG_RESET = 24'hffffff;

	// Register offsets on the plain port
	localparam logic [3:0] ADDR_CFG = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MASK = 4'h3;
	localparam logic [3:0] ADDR_COUNT = 4'h4;

	// Control register bits
	localparam int CTRL_SWEN = 0;
	localparam int CTRL_CLEAR = 1;

	// Status bit positions
	localparam int ST_EXPIRE = 0;
	localparam int ST_EARLY = 1;
	localparam int ST_CLEARED = 2;
	localparam int ST_W = 3;

	// Prescaler terminal counts (ratio minus one)
	localparam logic [7:0] PRE_SMALL = 8'h1f;
	localparam logic [7:0] PRE_LARGE = 8'h7f;

	// Reset pulse width in system clocks
	localparam logic [3:0] RST_PULSE = 4'h8;

	// Clock source codes
	typedef enum logic [1:0] {
		WWD_SRC_LOW_RC = 2'b00,
		WWD_SRC_PER = 2'b01,
		WWD_SRC_SECOND = 2'b11,
		WWD_SRC_FAST_RC = 2'b10
	} wwd_src_t;

	// Decoded configuration travelling between modules
	typedef struct packed {
		logic [1:0] clk_sel;
		logic clk_mux_en;
		logic [1:0] win_width;
		logic win_dis;
		logic [1:0] en_policy;
		logic pre_sel;
		logic [3:0] post_sel;
	} wwd_cfg_t;

	// System context inputs
	typedef struct packed {
		logic sysclk_is_low_rc;
		logic asleep;
	} wwd_ctx_t;

	// Decode the raw configuration word into fields
	function automatic wwd_cfg_t wwd_decode(input logic [23:0] w);
		wwd_cfg_t c;
		c.clk_sel = w[POS_CLK +: 2];
		c.clk_mux_en = w[POS_CMX];
		c.win_width = w[POS_WIN +: 2];
		c.win_dis = w[POS_WIN_DIS];
		c.en_policy = w[POS_EN +: 2];
		c.pre_sel = w[POS_PSA];
		c.post_sel = w[POS_PS +: 4];
		return c;
	endfunction : wwd_decode

endpackage : wwd_pkg

// [wwd_clk_sel.sv]
// Watchdog clock-source selector: picks one of four synchronised tick streams.
// Assumes tick inputs are already synchronised single-cycle pulses on sys_clk_in.
`timescale 1ns/1ps
module wwd_clk_sel (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Configuration and context
	input wire wwd_pkg::wwd_cfg_t cfg_in,
	input wire wwd_pkg::wwd_ctx_t ctx_in,
	// Source ticks
	input wire logic low_rc_tick_in,
	input wire logic per_tick_in,
	input wire logic second_tick_in,
	input wire logic fast_rc_tick_in,
	// Selected tick
	output logic tick_out,
	output wwd_pkg::wwd_src_t src_out
);
	import wwd_pkg::*;

	typedef struct packed {
		wwd_src_t src;
		logic tick;
	} wwd_sel_state_t;

	wwd_sel_state_t st_r;
	wwd_sel_state_t st_nxt;

	// Pick the source, then route that source's tick; registered to keep the mux glitch free
	always_comb begin
		st_nxt = st_r;
		if (!cfg_in.clk_mux_en) begin
			st_nxt.src = WWD_SRC_LOW_RC;
		end else begin
			unique case (cfg_in.clk_sel)
				2'b00: st_nxt.src = (ctx_in.sysclk_is_low_rc || ctx_in.asleep) ?
					WWD_SRC_LOW_RC : WWD_SRC_PER;
				2'b01: st_nxt.src = WWD_SRC_SECOND;
				2'b10: st_nxt.src = (!cfg_in.win_dis && !ctx_in.sysclk_is_low_rc &&
					!ctx_in.asleep) ? WWD_SRC_FAST_RC : WWD_SRC_LOW_RC;
				2'b11: st_nxt.src = WWD_SRC_LOW_RC;
			endcase
		end
		unique case (st_r.src)
			WWD_SRC_LOW_RC: st_nxt.tick = low_rc_tick_in;
			WWD_SRC_PER: st_nxt.tick = per_tick_in;
			WWD_SRC_SECOND: st_nxt.tick = second_tick_in;
			WWD_SRC_FAST_RC: st_nxt.tick = fast_rc_tick_in;
		endcase
		if (!rst_n_in) begin
			st_nxt.src = WWD_SRC_LOW_RC;
			st_nxt.tick = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		st_r <= st_nxt;
	end

	assign tick_out = st_r.tick;
	assign src_out = st_r.src;

	// Mux disabled forces the low-power source within two cycles
	mux_off_low_power_rc_osc_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!cfg_in.clk_mux_en ##1 !cfg_in.clk_mux_en |=> src_out == WWD_SRC_LOW_RC)
		else $error("mux off but source not low-power rc");
	secondary_osc_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		cfg_in.clk_mux_en && cfg_in.clk_sel == 2'b01 |=> src_out == WWD_SRC_SECOND)
		else $error("select 01 not secondary osc");
	frc_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		cfg_in.clk_mux_en && cfg_in.clk_sel == 2'b10 && ctx_in.asleep
		|=> src_out == WWD_SRC_LOW_RC)
		else $error("select 10 in sleep not low-power rc");

endmodule : wwd_clk_sel

// [wwd_sync.sv]
// Two-flop synchroniser bank for pin-level inputs.
// Assumes inputs are asynchronous to sys_clk_in.
`timescale 1ns/1ps
module wwd_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} wwd_sync_state_t;

	wwd_sync_state_t st_r;
	wwd_sync_state_t st_nxt;

	// The first stage feeds only the second stage
	always_comb begin
		st_nxt.meta = async_in;
		st_nxt.sync = st_r.meta;
		if (!rst_n_in) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		st_r <= st_nxt;
	end

	assign sync_out = st_r.sync;

endmodule : wwd_sync

// [wwd_top.sv]
// Windowed watchdog top: configuration word, prescaler, postscaler, window and reset.
// Assumes oscillator clocks arrive as slow square waves on pins, sampled at 40 MHz.
// Notes on behaviour
// - Mux bit set means the two-bit select field chooses the watchdog clock.
// - Mux bit clear means the low-power RC always clocks the watchdog.
// - Select 00 peripheral unless low-power system clock or sleep; 01 secondary; 11 low-power.
// - Select 10 uses fast RC only when windowed, system clock not low-power, awake.
// - Window width 11=25%, 10=37.5%, 01=50%, 00=75% of the period.
// - Window-disable bit one turns windowing off, zero turns it on.
// - Enable 11 runs always; 10 leaves running to the software enable bit.
// - Enable 01 runs only while awake; software enable ignored.
// - Enable 00 keeps the watchdog off and ignores software enable.
// - Prescale bit set divides by 128, clear divides by 32.
// - Postscale field selects two to the field value, 1:1 up to 1:32768.
// - Unused configuration bit 10 always reads back as one.
`timescale 1ns/1ps
module wwd_top (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Nonvolatile configuration word, stable after power-up
	input wire logic [23:0] cfg_word_in,
	// Oscillator clock pins
	input wire logic low_power_rc_osc_in,
	input wire logic per_clk_in,
	input wire logic secondary_osc_in,
	input wire logic fast_rc_osc_in,
	// System context, same clock domain
	input wire wwd_pkg::wwd_ctx_t ctx_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Results
	output logic wd_reset_out,
	output logic irq_out
);
	import wwd_pkg::*;

	typedef struct packed {
		logic [23:0] cfg;
		logic sw_en;
		logic [3:0] osc_prev;
		logic [6:0] pre_cnt;
		logic [14:0] post_cnt;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic [3:0] rst_cnt;
		logic rst_pulse;
		logic [31:0] rdata;
	} wwd_state_t;

	wwd_state_t st_r;
	wwd_state_t st_nxt;

	logic [3:0] osc_sync;
	logic wd_tick;
	wwd_cfg_t cfg;
	logic running;
	logic pre_done;
	logic [14:0] post_last;
	logic in_window;
	logic clear_req;
	logic expire;
	logic early;
	logic [ST_W-1:0] events;

	// Postscale terminal count: two to the field value, minus one
	function automatic logic [14:0] post_term(input logic [3:0] sel);
		logic [15:0] ratio;
		ratio = 16'h0001 << sel;
		return ratio[14:0] - 15'h0001;
	endfunction : post_term

	// Window opens when the count reaches the start of the final window share
	function automatic logic win_open(input logic [14:0] cnt, input logic [14:0] last,
		input logic [1:0] width);
		logic [15:0] len;
		logic [17:0] start8;
		len = {1'b0, last} + 16'h0001;
		unique case (width)
			2'b11: start8 = 18'(len) * 18'h6; // 75% closed, last 25% open
			2'b10: start8 = 18'(len) * 18'h5; // 37.5% window
			2'b01: start8 = 18'(len) * 18'h4; // 50% window
			2'b00: start8 = 18'(len) * 18'h2; // 75% window
		endcase
		return ({cnt, 3'h0} >= start8);
	endfunction : win_open

	// Oscillator pins pass two flops before use
	wwd_sync #(
		.WIDTH(4)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.async_in({fast_rc_osc_in, secondary_osc_in, per_clk_in, low_power_rc_osc_in}),
		.sync_out(osc_sync)
	);

	assign cfg = wwd_decode(st_r.cfg);

	// Clock source choice
	wwd_clk_sel u_clk_sel (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.cfg_in(cfg),
		.ctx_in(ctx_in),
		.low_rc_tick_in(osc_sync[0] & ~st_r.osc_prev[0]),
		.per_tick_in(osc_sync[1] & ~st_r.osc_prev[1]),
		.second_tick_in(osc_sync[2] & ~st_r.osc_prev[2]),
		.fast_rc_tick_in(osc_sync[3] & ~st_r.osc_prev[3]),
		.tick_out(wd_tick),
		.src_out()
	);

	// Enable policy decides whether the counters advance
	always_comb begin
		unique case (cfg.en_policy)
			2'b11: running = 1'b1;
			2'b10: running = st_r.sw_en;
			2'b01: running = !ctx_in.asleep;
			2'b00: running = 1'b0;
		endcase
	end

	// Prescale ends at 32 or 128 ticks; postscale at its terminal count
	assign pre_done = wd_tick && (st_r.pre_cnt == (cfg.pre_sel ? PRE_LARGE[6:0] :
		PRE_SMALL[6:0]));
	assign post_last = post_term(cfg.post_sel);
	assign expire = running && pre_done && (st_r.post_cnt >= post_last);
	// Windowing is off when the disable bit is one
	assign in_window = cfg.win_dis || win_open(st_r.post_cnt, post_last,
		cfg.win_width);
	assign clear_req = reg_wr_in && reg_addr_in == ADDR_CTRL && reg_wdata_in[CTRL_CLEAR];
	assign early = running && clear_req && !in_window;
	assign events = {running && clear_req && in_window, early, expire};

	// Next state: counters, registers, sticky status and reset pulse
	always_comb begin
		st_nxt = st_r;
		st_nxt.osc_prev = osc_sync;
		st_nxt.rdata = 32'h0;
		if (running && wd_tick) begin
			st_nxt.pre_cnt = pre_done ? 7'h00 : st_r.pre_cnt + 7'h01;
			if (pre_done) begin
				st_nxt.post_cnt = (st_r.post_cnt >= post_last) ? 15'h0000 :
					st_r.post_cnt + 15'h0001;
			end
		end
		if (!running || (clear_req && in_window)) begin
			st_nxt.pre_cnt = 7'h00;
			st_nxt.post_cnt = 15'h0000;
		end
		if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
			st_nxt.sw_en = reg_wdata_in[CTRL_SWEN];
		end
		if (reg_wr_in && reg_addr_in == ADDR_MASK) begin
			st_nxt.mask = reg_wdata_in[ST_W-1:0];
		end
		// Reading status clears it, but a same-cycle event still lands
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				ADDR_CFG: st_nxt.rdata = {8'h00, st_r.cfg | CFG_ONES_MASK};
				ADDR_CTRL: st_nxt.rdata = {31'h0, st_r.sw_en};
				ADDR_STATUS: st_nxt.rdata = {29'h0, st_r.status};
				ADDR_MASK: st_nxt.rdata = {29'h0, st_r.mask};
				ADDR_COUNT: st_nxt.rdata = {10'h0, st_r.post_cnt, st_r.pre_cnt};
				default: st_nxt.rdata = 32'h0;
			endcase
			if (reg_addr_in == ADDR_STATUS) begin
				st_nxt.status = '0;
			end
		end
		st_nxt.status = st_nxt.status | events;
		// Expiry or early clear holds the device reset for a fixed pulse
		if (expire || early) begin
			st_nxt.rst_cnt = RST_PULSE;
			st_nxt.rst_pulse = 1'b1;
			st_nxt.pre_cnt = 7'h00;
			st_nxt.post_cnt = 15'h0000;
		end else if (st_r.rst_cnt != 4'h0) begin
			st_nxt.rst_cnt = st_r.rst_cnt - 4'h1;
			st_nxt.rst_pulse = (st_r.rst_cnt != 4'h1);
		end
		if (!rst_n_in) begin
			st_nxt = '0;
			st_nxt.cfg = CFG_RESET;
		end else if (st_r.rst_cnt == 4'h0 && !st_r.rst_pulse && st_r.cfg == CFG_RESET) begin
			st_nxt.cfg = cfg_word_in; // Word latched once after reset release
		end
	end

	always_ff @(posedge sys_clk_in) begin
		st_r <= st_nxt;
	end

	assign reg_rdata_out = st_r.rdata;
	assign wd_reset_out = st_r.rst_pulse;
	assign irq_out = |(st_r.status & st_r.mask);

	// Checks
	sequence early_clear_s;
		running && clear_req && !in_window;
	endsequence

	early_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		early_clear_s |=> wd_reset_out ##1 wd_reset_out)
		else $error("early clear did not reset");
	expire_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		expire |=> wd_reset_out && st_r.status[ST_EXPIRE])
		else $error("expiry did not reset");
	policy_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		cfg.en_policy == 2'b00 |-> !running)
		else $error("policy 00 running");
	sleep_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		cfg.en_policy == 2'b01 && ctx_in.asleep |-> !running)
		else $error("policy 01 running in sleep");
	sw_policy_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		cfg.en_policy == 2'b10 |-> running == st_r.sw_en)
		else $error("policy 10 not following software bit");
	unused_one_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		reg_rd_in && reg_addr_in == ADDR_CFG |=> reg_rdata_out[POS_UNUSED10])
		else $error("bit 10 read as zero");
	prescale_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		running && wd_tick && !cfg.pre_sel && st_r.pre_cnt == 7'h1f && !expire &&
		!clear_req |=> st_r.pre_cnt == 7'h00)
		else $error("prescaler 1:32 wrap wrong");
	nowin_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		cfg.win_dis && running && clear_req && !expire |=> st_r.pre_cnt == 7'h00 &&
		st_r.post_cnt == 15'h0000 && !wd_reset_out)
		else $error("window disabled but clear refused");
	window_quarter_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!cfg.win_dis && cfg.win_width == 2'b11 && cfg.post_sel == 4'h3 |->
		in_window == (st_r.post_cnt >= 15'h0006))
		else $error("25 percent window wrong");

endmodule : wwd_top

// [wwd_top_tb_top.sv]
// Self-checking bench for the windowed watchdog top: a table of configurations, then window cases.
// Assumes the design files are compiled first; oscillator pins are free-running square waves.
`timescale 1ns/1ps
module wwd_top_tb_top;
	import wwd_pkg::*;
	// Row of the table: config word, context, software enable, source period in cycles (0: silent)
	typedef struct {
		logic [23:0] w;
		logic [1:0] cx;
		logic sw;
		int per;
	} wwd_row_t;
	// Stimulus and observed outputs
	logic sys_clk_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic [23:0] cfg = 24'h000000;
	logic osc_lp = 1'h0;
	logic osc_per = 1'h0;
	logic osc_sec = 1'h0;
	logic osc_fast = 1'h0;
	wwd_ctx_t ctx = '0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [31:0] rdata;
	logic wd_rst;
	logic irq;
	logic [31:0] d;
	logic [23:0] w;
	int err_count = 0;
	int checked = 0;
	int n;
	int e;
	int lim;
	int wst [4] = '{256, 512, 640, 768};
	wwd_row_t rows [18];

	// 40 MHz clock; oscillators of 4, 6, 8 and 10 cycles, toggling on its falling edges
	always #12.5 sys_clk_in = ~sys_clk_in;
	always #50 osc_lp = ~osc_lp;
	always #75 osc_per = ~osc_per;
	always #100 osc_sec = ~osc_sec;
	always #125 osc_fast = ~osc_fast;

	// Device under test
	wwd_top i_wwd_top (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.cfg_word_in(cfg),
		.low_power_rc_osc_in(osc_lp),
		.per_clk_in(osc_per),
		.secondary_osc_in(osc_sec),
		.fast_rc_osc_in(osc_fast),
		.ctx_in(ctx),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.wd_reset_out(wd_rst),
		.irq_out(irq)
	);

	// Build a config word from its fields; unused bits left zero so readback shows them forced
	function automatic logic [23:0] mk(input logic [1:0] cs, input logic mx, input logic [1:0] wn,
		input logic wd, input logic [1:0] en, input logic pa, input logic [3:0] ps);
		return {9'h000, cs, 1'h0, mx, 1'h0, wn, wd, en, pa, ps};
	endfunction : mk

	// Watchdog ticks to expiry: prescale ratio times two to the postscale field
	function automatic int tk(input logic [23:0] v);
		return (v[4] ? 128 : 32) << v[3:0];
	endfunction : tk

	task automatic fail(input string m);
		err_count++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : fail

	// Compare a register or output value
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) fail($sformatf("%s got %h want %h", m, got, exp));
	endtask : chk_word

	// Compare a measured span of cycles against bounds
	task automatic chk_span(input int got, input int lo, input int hi, input string m);
		checked++;
		if (got < lo || got > hi) fail($sformatf("%s took %0d want %0d..%0d", m, got, lo, hi));
	endtask : chk_span

	// One-cycle register write
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'h1;
		@(posedge sys_clk_in);
		wr <= 1'h0;
	endtask : wr_reg

	// One-cycle register read; data is only valid in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge sys_clk_in);
		addr <= a;
		rd <= 1'h1;
		@(posedge sys_clk_in);
		rd <= 1'h0;
		#1;
		v = rdata;
	endtask : rd_reg

	// Reset for five cycles with a new config word, so that the word is latched on release
	task automatic start(input logic [23:0] v, input logic [1:0] cx);
		@(posedge sys_clk_in);
		rst_n_in <= 1'h0;
		cfg <= v;
		ctx <= cx;
		repeat (4) @(posedge sys_clk_in);
		#1;
		chk_word({30'h0, wd_rst, irq}, 32'h0, "outputs in reset");
		@(posedge sys_clk_in);
		rst_n_in <= 1'h1;
		repeat (2) @(posedge sys_clk_in);
	endtask : start

	// Count cycles until the reset output rises, bounded by l
	task automatic wait_fire(input int l, output int c);
		c = 0;
		while (wd_rst !== 1'h1 && c < l) begin
			@(posedge sys_clk_in);
			#1;
			c++;
		end
	endtask : wait_fire

	task automatic conclude();
		$display("counts: %0d compared, %0d mismatched", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// Hang guard, about two and a half times the expected run
	initial begin
		#1ms;
		fail("watchdog of the bench ran out");
		conclude();
	end

	initial begin
		rows = '{
			'{mk(2'h1, 1'h0, 2'h3, 1'h1, 2'h3, 1'h0, 4'h0), 2'h0, 1'h0, 4},
			'{mk(2'h0, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 4'h0), 2'h0, 1'h0, 6},
			'{mk(2'h0, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 4'h0), 2'h1, 1'h0, 4},
			'{mk(2'h0, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 4'h0), 2'h2, 1'h0, 4},
			'{mk(2'h1, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 4'h0), 2'h0, 1'h0, 8},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 4'h0), 2'h0, 1'h0, 4},
			'{mk(2'h2, 1'h1, 2'h3, 1'h0, 2'h3, 1'h0, 4'h0), 2'h0, 1'h0, 10},
			'{mk(2'h2, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 4'h0), 2'h0, 1'h0, 4},
			'{mk(2'h2, 1'h1, 2'h3, 1'h0, 2'h3, 1'h0, 4'h0), 2'h1, 1'h0, 4},
			'{mk(2'h2, 1'h1, 2'h3, 1'h0, 2'h3, 1'h0, 4'h0), 2'h2, 1'h0, 4},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h3, 1'h1, 4'h0), 2'h0, 1'h0, 4},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 4'h3), 2'h0, 1'h0, 4},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h3, 1'h1, 4'h1), 2'h0, 1'h0, 4},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h1, 1'h0, 4'h0), 2'h0, 1'h0, 4},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h1, 1'h0, 4'h0), 2'h1, 1'h1, 0},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h2, 1'h0, 4'h0), 2'h0, 1'h0, 0},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h2, 1'h0, 4'h0), 2'h0, 1'h1, 4},
			'{mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h0, 1'h0, 4'h0), 2'h0, 1'h1, 0}
		};
		// Table: readback, then expiry time set by source, prescale, postscale and enable
		foreach (rows[i]) begin
			start(rows[i].w, rows[i].cx);
			rd_reg(ADDR_CFG, d);
			chk_word(d, {8'h00, rows[i].w | CFG_ONES_MASK}, "config readback");
			wr_reg(ADDR_CTRL, {31'h0, rows[i].sw});
			e = rows[i].per * tk(rows[i].w);
			lim = (e == 0) ? 600 : e + rows[i].per + 12;
			wait_fire(lim, n);
			if (e == 0) begin
				chk_span(n, lim, lim, "silent watchdog");
			end else begin
				chk_span(n, e - rows[i].per - 12, lim, "expiry");
				wait_fire(0, n);
				while (wd_rst === 1'h1 && n < 20) begin
					@(posedge sys_clk_in);
					#1;
					n++;
				end
				chk_span(n, int'(RST_PULSE), int'(RST_PULSE), "reset pulse");
				rd_reg(ADDR_STATUS, d);
				chk_word(d, 32'h1 << ST_EXPIRE, "expiry status");
			end
			$display("test row %0d done", i);
		end
		// Read-only and unmapped places ignore writes
		wr_reg(ADDR_CFG, 32'h00000000);
		rd_reg(ADDR_CFG, d);
		chk_word(d, {8'h00, rows[17].w | CFG_ONES_MASK}, "config after write");
		wr_reg(4'hf, 32'hffffffff);
		rd_reg(4'hf, d);
		chk_word(d, 32'h0, "unmapped read");
		$display("test register access done");
		// Each window width: a clear just early faults, one just inside is taken and restarts
		for (int k = 0; k < 4; k++) begin
			w = mk(2'h3, 1'h1, k[1:0], 1'h0, 2'h3, 1'h0, 4'h3);
			start(w, 2'h0);
			wr_reg(ADDR_MASK, 32'h0);
			repeat (wst[k] - 60) @(posedge sys_clk_in);
			wr_reg(ADDR_CTRL, 32'h2);
			wait_fire(3, n);
			chk_span(n, 0, 2, "early clear");
			chk_word({31'h0, irq}, 32'h0, "masked irq");
			wr_reg(ADDR_MASK, 32'h7);
			@(posedge sys_clk_in);
			#1;
			chk_word({31'h0, irq}, 32'h1, "unmasked irq");
			rd_reg(ADDR_STATUS, d);
			chk_word(d, 32'h1 << ST_EARLY, "early status");
			rd_reg(ADDR_STATUS, d);
			chk_word(d, 32'h0, "status after read");
			chk_word({31'h0, irq}, 32'h0, "irq after read");
			start(w, 2'h0);
			repeat (wst[k] + 60) @(posedge sys_clk_in);
			wr_reg(ADDR_CTRL, 32'h2);
			wait_fire(20, n);
			chk_span(n, 20, 20, "clear in window");
			rd_reg(ADDR_STATUS, d);
			chk_word(d, 32'h1 << ST_CLEARED, "good clear status");
			wait_fire(1100, n);
			chk_span(n, 985, 1020, "expiry after clear");
			$display("test window width %0d done", k);
		end
		// Window off: an early clear is taken and restarts, no fault
		start(mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 4'h3), 2'h0);
		repeat (100) @(posedge sys_clk_in);
		wr_reg(ADDR_CTRL, 32'h2);
		wait_fire(20, n);
		chk_span(n, 20, 20, "clear with window off");
		rd_reg(ADDR_STATUS, d);
		chk_word(d, 32'h1 << ST_CLEARED, "window off clear status");
		$display("test window off done");
		conclude();
	end
endmodule : wwd_top_tb_top
